/* inc/bldc_consts.svh */
// Purpose: constants for the lock detect and current limit supervisor
// Assumes: 40 MHz ref_clk
// Notes on behaviour
// - advance code 0x01 means 2.5 us, 0x7f means 4800 us, others per mantissa/exponent.
// - advance time is 2.5 us times code[3:0] shifted left by code[6:4].
// - mode 0 keeps advance fixed; mode 1 scales it by (amplitude-bemf)/amplitude.
// - overcurrent protection always active at fixed threshold, never configurable.
// - phase overcurrent stops drive; drive resumes once the indication clears.
// - acceleration limit caps amplitude at ilimit*resistance plus speed*bemf constant.
// - acceleration limit applies only in closed loop.
// - acceleration limit keeps driving and raises no fault.
// - five lock schemes plus no-motor scheme combine into one lock response.
// - six enable bits; a cleared bit blocks that scheme's lock response.
// - any enabled lock sets the motor locked flag.
// - fault source register records which conditions occurred.
// - fault source bits reload from that cycle's detections when the motor restarts.
// - fault source bits set even for disabled schemes.
// - lock or no-motor puts all drivers in high impedance.
// - anti-surge process runs on every entry into high impedance.
// - after fault high impedance, wait retry delay then restart.
// - low-side current above lock threshold tri-states, flags lock, retries later.
// - two bemf estimates: from U current and resistance, from speed and constant.
// - bemf estimate well above amplitude for qualify time declares lock.
// - bemf integral per half cycle is measured in closed loop only as lock criterion.
// - window select gives bounds around constant; outside for qualify time is lock.
// - after open-to-closed handoff, U current not above 140 mA is no-motor fault.
// - closed loop commutation period over twice previous declares lock.
`ifndef BLDC_CONSTS_SVH
`define BLDC_CONSTS_SVH
`define BLDC_CLK_HZ          40000000
`define BLDC_ADV_STEP_NS     2500
`define BLDC_QUALIFY_MS      100
`define BLDC_RETRY_MS        5000
`define BLDC_NOMOTOR_MA      140
`define BLDC_SCH_CURLIM      0
`define BLDC_SCH_SPEED       1
`define BLDC_SCH_KT          2
`define BLDC_SCH_NOMOTOR     3
`define BLDC_SCH_OPENLOOP    4
`define BLDC_SCH_STUCK       5
`define BLDC_ENABLES_RST     6'h3f
`define BLDC_ADV_RST         7'h00
`endif

/* inc/bldc_pkg.sv */
// Purpose: types for the supervisor
// Assumes: nothing
// Notes: states and grouped config
package bldc_pkg;
   typedef enum logic [1:0] {BLDC_RUN, BLDC_HIZ, BLDC_WAIT} bldc_state_t;
   typedef struct packed {
      logic [6:0] advanceTimeCode;
      logic       advanceModeSelect;
      logic [3:0] accelCurrentLimitThreshold;
      logic [2:0] lockCurrentThreshold;
      logic [5:0] lockSchemeEnables;
      logic [1:0] ktWindowSelect;
      logic [6:0] bemfConstant;
      logic [6:0] phaseResistanceSetting;
   } bldc_cfg_t;
endpackage

/* hw/bldc_supervisor.sv */
// Purpose: lock detect, current limit, fault and restart supervisor
// Assumes: measurements sampled on ref_clk; pins pass two flops
// Notes: register port: 4 words, read data one cycle later
`timescale 1ns/10ps
`include "bldc_consts.svh"
module bldc_supervisor #(
   parameter int QUALIFY_CYC = `BLDC_QUALIFY_MS * (`BLDC_CLK_HZ / 1000),
   parameter int RETRY_CYC   = `BLDC_RETRY_MS * (`BLDC_CLK_HZ / 1000),
   parameter int AVS_CYC     = 64
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // register port
   input  wire logic [1:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic      [31:0] regRdata,
   // motor state inputs
   input  wire logic        closedLoop,
   input  wire logic        handoffPulse,
   input  wire logic        halfCyclePulse,
   input  wire logic        commutatePulse,
   input  wire logic        openLoopNoBemf,
   input  wire logic [15:0] speedHz,
   input  wire logic [11:0] uCurrentMa,
   input  wire logic [11:0] lowSideCurrentMa,
   input  wire logic [15:0] amplitude,
   input  wire logic [15:0] bemfIntegral,
   input  wire logic        ocPin,
   // outputs
   output logic             phaseHighZ,
   output logic             antiSurgeActive,
   output logic             restartPulse,
   output logic [15:0]      amplitudeLimit,
   output logic             accelLimitActive,
   output logic [22:0]      advanceTimeNs,
   output logic             motorLockedFlag,
   output logic [5:0]       faultSourceRegister
);
   // ----------------------------------------
   // functions
   // ----------------------------------------
   function automatic logic [31:0] mul16(input logic [15:0] a, input logic [15:0] b);
      mul16 = 32'(a) * 32'(b);
   endfunction
   function automatic logic [15:0] sat16(input logic [31:0] v);
      sat16 = (v[31:16] != 16'h0000) ? 16'hffff : v[15:0];
   endfunction

   // ----------------------------------------
   // registers
   // ----------------------------------------
   bldc_pkg::bldc_cfg_t cfg;
   logic                ocSync1;
   logic                ocSync2;
   bldc_pkg::bldc_state_t state;
   logic [31:0]         waitCnt;
   logic [31:0]         speedCnt;
   logic [31:0]         ktCnt;
   logic [31:0]         commCnt;
   logic [31:0]         prevPeriod;
   logic                prevValid;
   logic [5:0]          detect;
   logic                lockHit;
   logic [15:0]         bemfSpeed;
   logic [15:0]         bemfCurrent;
   logic [15:0]         accelCap;
   logic [15:0]         ktLow;
   logic [15:0]         ktHigh;
   logic [22:0]         baseAdv;
   logic [63:0]         scaledAdv;
   logic                hizPrev;
   logic [31:0]         ocSurgeCnt;
   logic                speedHit;
   logic                ktHit;

   // ----------------------------------------
   // configuration word: low part at 0, high part at 3
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cfg.advanceTimeCode            <= `BLDC_ADV_RST;
         cfg.advanceModeSelect          <= 1'b0;
         cfg.accelCurrentLimitThreshold <= 4'h0;
         cfg.lockCurrentThreshold       <= 3'h7;
         cfg.lockSchemeEnables          <= `BLDC_ENABLES_RST;
         cfg.ktWindowSelect             <= 2'h0;
         cfg.bemfConstant               <= 7'h00;
         cfg.phaseResistanceSetting     <= 7'h00;
      end else begin
         if (regWrite && regAddr == 2'h0) begin
            cfg[31:0] <= regWdata;
         end
         if (regWrite && regAddr == 2'h3) begin
            cfg[36:32] <= regWdata[4:0];
         end
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         regRdata <= 32'h0;
      end else if (regRead) begin
         unique case (regAddr)
            2'h0: begin
               regRdata <= cfg[31:0];
            end
            2'h1: begin
               regRdata <= {23'h0, ocSync2, phaseHighZ, motorLockedFlag, faultSourceRegister};
            end
            2'h2: begin
               regRdata <= {9'h0, advanceTimeNs};
            end
            2'h3: begin
               regRdata <= {27'h0, cfg[36:32]};
            end
         endcase
      end else begin
         regRdata <= 32'h0;
      end
   end

   // ----------------------------------------
   // advance time
   // ----------------------------------------
   always_comb begin
      baseAdv = 23'((32'(cfg.advanceTimeCode[3:0]) * `BLDC_ADV_STEP_NS) << cfg.advanceTimeCode[6:4]);
      if (amplitude == 16'h0 || bemfSpeed >= amplitude) begin
         scaledAdv = 64'h0;
      end else begin
         scaledAdv = (64'(baseAdv) * 64'(amplitude - bemfSpeed)) / 64'(amplitude);
      end
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         advanceTimeNs <= 23'h0;
      end else if (cfg.advanceModeSelect) begin
         advanceTimeNs <= 23'(scaledAdv);
      end else begin
         advanceTimeNs <= baseAdv;
      end
   end

   // ----------------------------------------
   // estimates and current limits
   // ----------------------------------------
   always_comb begin
      bemfSpeed   = sat16(mul16(speedHz, 16'(cfg.bemfConstant)));
      bemfCurrent = amplitude - sat16(mul16(16'(uCurrentMa), 16'(cfg.phaseResistanceSetting)));
      accelCap    = sat16(32'(sat16(mul16(16'(cfg.accelCurrentLimitThreshold) + 16'h1, 16'h0064) * 32'(cfg.phaseResistanceSetting) >> 4)) + 32'(bemfSpeed));
      ktLow       = 16'(cfg.bemfConstant) - 16'((16'(cfg.bemfConstant) >> (3 - cfg.ktWindowSelect)));
      ktHigh      = 16'(cfg.bemfConstant) + 16'((16'(cfg.bemfConstant) >> (3 - cfg.ktWindowSelect)));
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         amplitudeLimit   <= 16'hffff;
         accelLimitActive <= 1'b0;
      end else if (closedLoop) begin
         amplitudeLimit   <= accelCap;
         accelLimitActive <= amplitude > accelCap;
      end else begin
         amplitudeLimit   <= 16'hffff;
         accelLimitActive <= 1'b0;
      end
   end

   // ----------------------------------------
   // overcurrent: fixed, resumes when clear
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ocSync1 <= 1'b0;
         ocSync2 <= 1'b0;
      end else begin
         ocSync1 <= ocPin;
         ocSync2 <= ocSync1;
      end
   end

   // ----------------------------------------
   // detection schemes
   // ----------------------------------------
   function automatic logic [31:0] qualify_next(input logic hit, input logic [31:0] cnt);
      if (!hit) begin
         qualify_next = 32'h0;
      end else if (cnt < 32'(QUALIFY_CYC)) begin
         qualify_next = cnt + 32'h1;
      end else begin
         qualify_next = cnt;
      end
   endfunction

   always_comb begin
      speedHit = closedLoop && 17'(bemfSpeed) > 17'(amplitude) + 17'(amplitude >> 2)
                 && bemfCurrent < bemfSpeed;
      ktHit    = closedLoop && (bemfIntegral < ktLow || bemfIntegral > ktHigh);
   end

   // ----------------------------------------
   // abnormal speed qualify counter
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         speedCnt <= 32'h0;
      end else if (state != bldc_pkg::BLDC_RUN) begin
         speedCnt <= 32'h0;
      end else begin
         speedCnt <= qualify_next(speedHit, speedCnt);
      end
   end

   // ----------------------------------------
   // abnormal kt qualify counter
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ktCnt <= 32'h0;
      end else if (state != bldc_pkg::BLDC_RUN) begin
         ktCnt <= 32'h0;
      end else begin
         ktCnt <= qualify_next(ktHit, ktCnt);
      end
   end

   // ----------------------------------------
   // commutation period watch
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         commCnt    <= 32'h0;
         prevPeriod <= 32'h0;
         prevValid  <= 1'b0;
      end else if (!closedLoop || state != bldc_pkg::BLDC_RUN) begin
         commCnt    <= 32'h0;
         prevPeriod <= 32'h0;
         prevValid  <= 1'b0;
      end else if (commutatePulse) begin
         commCnt    <= 32'h0;
         prevPeriod <= commCnt;
         prevValid  <= 1'b1;
      end else if (commCnt != 32'hffffffff) begin
         commCnt <= commCnt + 32'h1;
      end
   end

   // ----------------------------------------
   // scheme results and lock decision
   // ----------------------------------------
   always_comb begin
      detect                     = 6'h0;
      detect[`BLDC_SCH_CURLIM]   = lowSideCurrentMa > {1'b0, cfg.lockCurrentThreshold, 8'hff};
      detect[`BLDC_SCH_SPEED]    = speedCnt >= 32'(QUALIFY_CYC);
      detect[`BLDC_SCH_KT]       = ktCnt >= 32'(QUALIFY_CYC) && halfCyclePulse;
      detect[`BLDC_SCH_NOMOTOR]  = handoffPulse && uCurrentMa <= 12'(`BLDC_NOMOTOR_MA);
      detect[`BLDC_SCH_OPENLOOP] = !closedLoop && openLoopNoBemf;
      detect[`BLDC_SCH_STUCK]    = closedLoop && prevValid && commCnt > {prevPeriod[30:0], 1'b0};
      lockHit = state == bldc_pkg::BLDC_RUN && |(detect & cfg.lockSchemeEnables);
   end

   // ----------------------------------------
   // fault state machine
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= bldc_pkg::BLDC_RUN;
      end else begin
         unique case (state)
            bldc_pkg::BLDC_RUN: begin
               if (lockHit) begin
                  state <= bldc_pkg::BLDC_HIZ;
               end
            end
            bldc_pkg::BLDC_HIZ: begin
               if (waitCnt >= 32'(AVS_CYC - 1)) begin
                  state <= bldc_pkg::BLDC_WAIT;
               end
            end
            bldc_pkg::BLDC_WAIT: begin
               if (waitCnt >= 32'(RETRY_CYC - 1)) begin
                  state <= bldc_pkg::BLDC_RUN;
               end
            end
            default: begin
               state <= bldc_pkg::BLDC_RUN;
            end
         endcase
      end
   end

   // ----------------------------------------
   // anti-surge and retry timer
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         waitCnt <= 32'h0;
      end else begin
         unique case (state)
            bldc_pkg::BLDC_RUN: begin
               waitCnt <= 32'h0;
            end
            bldc_pkg::BLDC_HIZ: begin
               if (waitCnt >= 32'(AVS_CYC - 1)) begin
                  waitCnt <= 32'h0;
               end else begin
                  waitCnt <= waitCnt + 32'h1;
               end
            end
            bldc_pkg::BLDC_WAIT: begin
               waitCnt <= waitCnt + 32'h1;
            end
            default: begin
               waitCnt <= 32'h0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // anti-surge window on overcurrent entry
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         hizPrev <= 1'b0;
      end else begin
         hizPrev <= phaseHighZ;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ocSurgeCnt <= 32'h0;
      end else if (phaseHighZ && !hizPrev && state == bldc_pkg::BLDC_RUN) begin
         ocSurgeCnt <= 32'(AVS_CYC);
      end else if (ocSurgeCnt != 32'h0) begin
         ocSurgeCnt <= ocSurgeCnt - 32'h1;
      end
   end

   // ----------------------------------------
   // drive and restart outputs
   // ----------------------------------------
   always_comb begin
      phaseHighZ      = state != bldc_pkg::BLDC_RUN || ocSync2;
      antiSurgeActive = state == bldc_pkg::BLDC_HIZ || ocSurgeCnt != 32'h0;
      restartPulse    = state == bldc_pkg::BLDC_WAIT && waitCnt >= 32'(RETRY_CYC - 1);
   end

   // ----------------------------------------
   // lock flag and fault source bits
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         motorLockedFlag <= 1'b0;
      end else if (lockHit) begin
         motorLockedFlag <= 1'b1;
      end else if (restartPulse) begin
         motorLockedFlag <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         faultSourceRegister <= 6'h0;
      end else if (restartPulse) begin
         faultSourceRegister <= detect;
      end else begin
         faultSourceRegister <= faultSourceRegister | detect;
      end
   end
endmodule

/* sim/bldc_motor_model.sv */
// Purpose: winding stand-in for the supervisor
// Assumes: stall current and U current flow only while the bridge drives
// Notes: stall and missing motor on command
`timescale 1ns/10ps
module bldc_motor_model (
   // bench commands
   input  wire logic        ref_clk,
   input  wire logic        stall,
   input  wire logic        noMotor,
   input  wire logic        phaseHighZ,
   // measured currents
   output logic      [11:0] lowSideCurrentMa,
   output logic      [11:0] uCurrentMa
);
   // ----------
   // currents follow drive state
   // ----------
   initial lowSideCurrentMa = 12'h010;
   initial uCurrentMa = 12'h1f4;
   always @(posedge ref_clk) begin
      lowSideCurrentMa <= (stall && !phaseHighZ) ? 12'hfff : 12'h010;
      uCurrentMa <= phaseHighZ ? 12'h000 : (noMotor ? 12'h064 : 12'h1f4);
   end
endmodule

/* sim/bldc_supervisor_checker.sv */
// Purpose: port checker for the supervisor
// Assumes: short counts from the bench
// Notes: bound to every supervisor instance
`timescale 1ns/10ps
module bldc_supervisor_checker #(parameter int QUALIFY_CYC = 10, RETRY_CYC = 20, AVS_CYC = 64) (
   // clock and inputs
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire logic        closedLoop,
   input wire logic        handoffPulse,
   input wire logic [11:0] uCurrentMa,
   input wire logic [11:0] lowSideCurrentMa,
   input wire logic        ocPin,
   // outputs
   input wire logic        phaseHighZ,
   input wire logic        antiSurgeActive,
   input wire logic        restartPulse,
   input wire logic        accelLimitActive,
   input wire logic        motorLockedFlag,
   input wire logic [5:0]  faultSourceRegister
);
   // ----------
   // port relations
   // ----------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   chk_hiz_on_lock: assert property ($rose(motorLockedFlag) |-> ##[0:2] phaseHighZ)
      else $error("lock without high impedance");
   chk_lock_source: assert property ($rose(motorLockedFlag) |-> ##[0:1] faultSourceRegister != 6'h00)
      else $error("lock without source bit");
   chk_surge_on_hiz: assert property ($rose(phaseHighZ) |-> ##[0:1] antiSurgeActive)
      else $error("no anti-surge on high impedance");
   chk_surge_hold: assert property ($rose(antiSurgeActive) |-> antiSurgeActive[*8])
      else $error("anti-surge cut short");
   chk_restart_after: assert property (restartPulse |-> $past(phaseHighZ))
      else $error("restart without high impedance");
   chk_restart_clear: assert property (restartPulse && lowSideCurrentMa < 12'h0ff |=> faultSourceRegister == 6'h00)
      else $error("source bits kept over restart");
   chk_oc_stop: assert property (ocPin[*4] |-> phaseHighZ)
      else $error("overcurrent left drive on");
   chk_accel_open: assert property (!closedLoop[*2] |-> !accelLimitActive)
      else $error("accel limit in open loop");
   chk_cur_source: assert property ((lowSideCurrentMa == 12'hfff)[*3] |-> ##[0:1] faultSourceRegister[0])
      else $error("current lock source missing");
   chk_nomotor_src: assert property (handoffPulse && uCurrentMa <= 12'h08c |-> ##[1:2] faultSourceRegister[3])
      else $error("no-motor source missing");
endmodule
bind bldc_supervisor bldc_supervisor_checker #(.QUALIFY_CYC(QUALIFY_CYC), .RETRY_CYC(RETRY_CYC), .AVS_CYC(AVS_CYC))
   chk_u (.ref_clk(ref_clk), .reset(reset), .closedLoop(closedLoop), .handoffPulse(handoffPulse),
   .uCurrentMa(uCurrentMa), .lowSideCurrentMa(lowSideCurrentMa), .ocPin(ocPin), .phaseHighZ(phaseHighZ),
   .antiSurgeActive(antiSurgeActive), .restartPulse(restartPulse), .accelLimitActive(accelLimitActive),
   .motorLockedFlag(motorLockedFlag), .faultSourceRegister(faultSourceRegister));

/* sim/test_bldc_supervisor.sv */
// Purpose: self-checking bench for the supervisor
// Assumes: retry count 20, qualify count 10
// Notes: winding stand-in makes the currents
`timescale 1ns/10ps
module test_bldc_supervisor;
   // ----------
   // stimulus and model state
   // ----------
   logic        ref_clk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, ocPin = 1'b0;
   logic        closedLoop = 1'b0, handoffPulse = 1'b0, stall = 1'b0, noMotor = 1'b0;
   logic        commutatePulse = 1'b0, openLoopNoBemf = 1'b0;
   bldc_pkg::bldc_cfg_t cw;
   logic [1:0]  regAddr = 2'h0;
   logic [31:0] regWdata = 32'h0, regRdata;
   logic [15:0] speedHz = 16'h0, amplitude = 16'hffff, amplitudeLimit;
   logic [11:0] uCurrentMa, lowSideCurrentMa;
   logic        phaseHighZ, antiSurgeActive, restartPulse, accelLimitActive, motorLockedFlag;
   logic [22:0] advanceTimeNs;
   logic [5:0]  faultSourceRegister;
   int          fails = 0, checks_done = 0, expSrc = 0, n = 0, code = 0;
   always #12.5 ref_clk = ~ref_clk;
   bldc_motor_model mot_u (.ref_clk(ref_clk), .stall(stall), .noMotor(noMotor), .phaseHighZ(phaseHighZ),
      .lowSideCurrentMa(lowSideCurrentMa), .uCurrentMa(uCurrentMa));
   bldc_supervisor #(.QUALIFY_CYC(10), .RETRY_CYC(20)) dut_u (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .closedLoop(closedLoop),
      .handoffPulse(handoffPulse), .halfCyclePulse(1'b0), .commutatePulse(commutatePulse),
      .openLoopNoBemf(openLoopNoBemf),
      .speedHz(speedHz), .uCurrentMa(uCurrentMa), .lowSideCurrentMa(lowSideCurrentMa), .amplitude(amplitude),
      .bemfIntegral(16'h0000), .ocPin(ocPin), .phaseHighZ(phaseHighZ), .antiSurgeActive(antiSurgeActive),
      .restartPulse(restartPulse), .amplitudeLimit(amplitudeLimit), .accelLimitActive(accelLimitActive),
      .advanceTimeNs(advanceTimeNs), .motorLockedFlag(motorLockedFlag), .faultSourceRegister(faultSourceRegister));
   function automatic bldc_pkg::bldc_cfg_t cfgw(input logic [5:0] en, input logic [6:0] adv);
      bldc_pkg::bldc_cfg_t c;
      c = '0;
      c.lockSchemeEnables = en;
      c.advanceTimeCode = adv;
      c.accelCurrentLimitThreshold = 4'h1;
      return c;
   endfunction
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] v);
      checks_done++;
      if (v !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", s, e, v);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask
   task automatic wrcfg(input bldc_pkg::bldc_cfg_t c);
      wr(2'h0, c[31:0]);
      wr(2'h3, {27'h0, c[36:32]});
   endtask
   task automatic rd(input logic [1:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      regAddr <= a;
      regRead <= 1'b1;
      tick(1);
      regRead <= 1'b0;
      cmp("read data", e, regRdata);
   endtask
   task automatic waitfor(input logic v, input int k);
      n = 0;
      while ((v ? phaseHighZ : restartPulse) !== 1'b1 && n < k) begin
         tick(1);
         n++;
      end
   endtask
   task automatic finish_test;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #500000;
      fails++;
      finish_test();
   end
   initial begin
      void'($urandom(32'haa96abed));
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      for (int a = 0; a < 4; a++) begin
         code = (a == 0) ? 1 : (a == 1) ? 127 : int'($urandom % 128);
         cw = cfgw(6'h00, 7'(code));
         wrcfg(cw);
         rd(2'h2, ((code % 16) * 2500) << (code / 16));
      end
      wr(2'h2, 32'hffffffff);
      rd(2'h2, ((code % 16) * 2500) << (code / 16));
      rd(2'h0, cw[31:0]);
      rd(2'h3, {27'h0, cw[36:32]});
      $display("test registers done");
      @(posedge ref_clk);
      noMotor <= 1'b1;
      closedLoop <= 1'b1;
      tick(3);
      handoffPulse <= 1'b1;
      tick(1);
      handoffPulse <= 1'b0;
      expSrc = 8;
      rd(2'h1, 32'h008);
      closedLoop <= 1'b0;
      openLoopNoBemf <= 1'b1;
      tick(1);
      openLoopNoBemf <= 1'b0;
      closedLoop <= 1'b1;
      rd(2'h1, 32'h018);
      expSrc = 24;
      $display("test disabled no-motor done");
      wrcfg(cfgw(6'h3f, 7'h00));
      noMotor <= 1'b0;
      stall <= 1'b1;
      expSrc = expSrc | 1;
      waitfor(1'b1, 20);
      cmp("locked state", {4'hf, expSrc[5:0]}, {phaseHighZ, antiSurgeActive, motorLockedFlag, 1'b1, faultSourceRegister});
      stall <= 1'b0;
      waitfor(1'b0, 300);
      cmp("retry wait", 1, n >= 20 && n < 300);
      tick(2);
      cmp("after restart", 0, {phaseHighZ, faultSourceRegister});
      $display("test current lock done");
      wrcfg(cfgw(6'h00, 7'h00));
      ocPin <= 1'b1;
      waitfor(1'b1, 10);
      cmp("oc stop", 1, phaseHighZ);
      ocPin <= 1'b0;
      n = 0;
      while (phaseHighZ !== 1'b0 && n < 150) begin
         tick(1);
         n++;
      end
      cmp("oc resume", 0, phaseHighZ);
      $display("test overcurrent done");
      for (int i = 0; i < 24; i++) begin
         closedLoop <= i[2];
         amplitude <= 16'($urandom);
         speedHz <= 16'($urandom);
         tick(3);
         cmp("accel limit", {(i[2] ? 16'h0000 : 16'hffff), i[2] && amplitude != 16'h0}, {amplitudeLimit, accelLimitActive});
         cmp("no fault", 0, {phaseHighZ, faultSourceRegister});
      end
      $display("test accel limit done");
      finish_test();
   end
endmodule
